// file: vectored_interrupt_prioritizer.v
// Vectored interrupt prioritizer with APB register access
//
// How it works
// RULE1: seventeen sources feed sixteen vectors
// RULE2: twelve pin sources, five peripheral sources
// RULE3: comparator shares the port A pin 6 vector
// RULE4: eight selectable-edge pins, four dual-edge pins
// RULE5: port C 3..0 on 0030H..0036H, pin 3 first
// RULE6: port A 7..0 on 0018H..0026H, pin 7 first
// RULE7: each source gets one of three levels
// RULE8: watchdog interrupt uses 0004H below reset
// RULE9: vector MSB at even, LSB at odd address
// RULE10: polling leaves pending state readable, no vectoring
// RULE11: reset 0002H top, oscillator traps follow watchdog
// RULE12: illegal instruction trap 0006H after oscillator traps
// RULE13: converter and some pins absent on variants
// RULE14: timers 000AH/000CH, converter 0016H, reserved unused
// RULE15: highest ranked request wins, others stay pending
// RULE16: master enable set/cleared by listed events
// RULE17: level 3 over 2 over 1, traps level 3
// RULE18: sources signal one-cycle request pulses
// RULE19: pending set by pulse, cleared by ack or write
`timescale 1ns/1ps
`include "vip_consts.vh"
module vectored_interrupt_prioritizer #(
    parameter HAS_ADC = 1,
    parameter [7:0] PORT_A_PRESENT = 8'hff,
    parameter [3:0] PORT_C_PRESENT = 4'hf
) (
    input wire i_clk_sys, // System clock, 100 MHz
    input wire i_arst_n, // Asynchronous reset, active low
    input wire i_psel, // APB select
    input wire i_penable, // APB enable
    input wire i_pwrite, // APB write
    input wire [7:0] i_paddr, // APB byte address
    input wire [31:0] i_pwdata, // APB write data
    output reg [31:0] o_prdata, // APB read data
    output wire o_pready, // APB ready
    output wire o_pslverr, // APB error on unmapped address
    input wire i_t1_pulse, // Timer 1 request pulse
    input wire i_t0_pulse, // Timer 0 request pulse
    input wire i_adc_pulse, // Converter request pulse
    input wire i_cmp_pulse, // Comparator output request pulse
    input wire i_wdt_pulse, // Watchdog interrupt pulse
    input wire i_posc_fail, // Primary oscillator fail pulse
    input wire i_wosc_fail, // Watchdog oscillator fail pulse
    input wire i_illegal_op, // Illegal instruction pulse
    input wire [7:0] i_port_a, // Port A pins, asynchronous
    input wire [3:0] i_port_c, // Port C pins 3..0, asynchronous
    input wire i_ei, // Enable-interrupt instruction pulse
    input wire i_di, // Disable-interrupt instruction pulse
    input wire i_iret, // Return-from-interrupt pulse
    input wire i_trap_op, // Trap instruction pulse
    input wire i_ack, // Core takes the presented vector
    output reg [15:0] o_vector_msb_addr, // Even address, vector MSB
    output reg [15:0] o_vector_lsb_addr, // Odd address, vector LSB
    output reg o_vector_valid, // A vector is presented
    output wire o_global_irq_enable, // Master enable state
    output wire o_irq // Level interrupt from status
);
    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    localparam NS = `VIP_NSLOT;
    reg gie_r;
    reg [NS-1:0] req_r;
    reg [NS-1:0] req_nxt;
    reg [NS-1:0] lvlh_r;
    reg [NS-1:0] lvll_r;
    reg [7:0] edge_r;
    reg [3:0] trap_r;
    reg [3:0] trap_nxt;
    reg [`VIP_NSTAT-1:0] stat_r;
    reg [`VIP_NSTAT-1:0] irq_en_r;
    reg [11:0] pin_s1_r;
    reg [11:0] pin_s2_r;
    reg [11:0] pin_prev_r;
    reg [NS-1:0] src;
    reg [NS-1:0] present;
    reg [NS-1:0] win_slot_r;
    reg [3:0] win_trap_r;
    reg [NS-1:0] win_slot;
    reg [3:0] win_trap;
    reg [15:0] win_vec;
    reg found;
    reg [1:0] lv;
    reg [31:0] rdata;
    reg hit;
    integer k;
    integer m;
    integer j;
    wire [11:0] rise;
    wire [11:0] fall;
    wire [11:0] pin_evt;
    wire wr;
    wire rd_setup;
    wire ack_go;

    // ---------------------------------------------------------------
    // APB decode
    // ---------------------------------------------------------------
    // Zero-wait slave; writes commit in the access phase
    assign o_pready = 1'b1;
    assign wr = i_psel & i_penable & i_pwrite;
    assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
    assign o_pslverr = i_psel & i_penable & ~hit;
    assign o_global_irq_enable = gie_r;
    assign o_irq = |(stat_r & irq_en_r);
    assign ack_go = i_ack & o_vector_valid;

    // Address hit and read mux
    always @* begin
        hit = 1'b1;
        rdata = 32'h0000_0000;
        case (i_paddr)
            `VIP_OFS_CTRL: rdata[`VIP_CTRL_GIE_BIT] = gie_r;
            `VIP_OFS_REQ: rdata[NS-1:0] = req_r; // [RULE10]
            `VIP_OFS_LVLH: rdata[NS-1:0] = lvlh_r;
            `VIP_OFS_LVLL: rdata[NS-1:0] = lvll_r;
            `VIP_OFS_EDGE: rdata[7:0] = edge_r;
            `VIP_OFS_TRAP: rdata[3:0] = trap_r;
            `VIP_OFS_STAT: rdata[`VIP_NSTAT-1:0] = stat_r;
            `VIP_OFS_CLR: rdata = 32'h0000_0000;
            `VIP_OFS_EN: rdata[`VIP_NSTAT-1:0] = irq_en_r;
            `VIP_OFS_VEC: rdata[15:0] = o_vector_msb_addr;
            default: hit = 1'b0;
        endcase
    end

    // Read data captured in the setup cycle, stands through access
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            o_prdata <= rdata;
        end
    end

    // ---------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ---------------------------------------------------------------
    // Two flops per pin, then a history flop for edges
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_s1_r <= 12'h000;
            pin_s2_r <= 12'h000;
            pin_prev_r <= 12'h000;
        end else begin
            pin_s1_r <= {i_port_a, i_port_c};
            pin_s2_r <= pin_s1_r;
            pin_prev_r <= pin_s2_r;
        end
    end
    assign rise = pin_s2_r & ~pin_prev_r;
    assign fall = ~pin_s2_r & pin_prev_r;

    // Port A selectable edge, port C both edges
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_pa
            assign pin_evt[4+g] = edge_r[g] ? rise[4+g] : fall[4+g]; // [RULE4]
        end
        for (g = 0; g < 4; g = g + 1) begin : g_pc
            assign pin_evt[g] = rise[g] | fall[g]; // [RULE4]
        end
    endgenerate

    // Map sources onto slots in rank order
    always @* begin
        src = {NS{1'b0}};
        present = {NS{1'b1}};
        src[`VIP_SLOT_T1] = i_t1_pulse; // [RULE14] [RULE18]
        src[`VIP_SLOT_T0] = i_t0_pulse; // [RULE14]
        src[`VIP_SLOT_ADC] = i_adc_pulse; // [RULE14]
        present[`VIP_SLOT_ADC] = (HAS_ADC != 0); // [RULE13]
        // Own loop index, so this block never wakes the resolver
        for (m = 0; m < 8; m = m + 1) begin
            // Pin 7 takes the lowest slot of port A
            src[`VIP_SLOT_PA7 + m] = pin_evt[11-m]; // [RULE6] [RULE2]
            present[`VIP_SLOT_PA7 + m] = PORT_A_PRESENT[7-m]; // [RULE13]
        end
        src[`VIP_SLOT_PA6] = pin_evt[10] | i_cmp_pulse; // [RULE3] [RULE1]
        for (m = 0; m < 4; m = m + 1) begin
            src[`VIP_SLOT_PC3 + m] = pin_evt[3-m]; // [RULE5] [RULE2]
            present[`VIP_SLOT_PC3 + m] = PORT_C_PRESENT[3-m]; // [RULE13]
        end
        src = src & present;
    end

    // ---------------------------------------------------------------
    // Pending request and trap state
    // ---------------------------------------------------------------
    // Ack or write clears, source pulse set wins over both
    always @* begin
        req_nxt = req_r;
        trap_nxt = trap_r;
        if (ack_go) begin
            req_nxt = req_r & ~win_slot_r; // [RULE19]
            trap_nxt = trap_r & ~win_trap_r;
        end
        if (wr && i_paddr == `VIP_OFS_REQ) begin
            req_nxt = i_pwdata[NS-1:0] & present; // [RULE19]
        end
        req_nxt = req_nxt | src; // [RULE19]
        trap_nxt = trap_nxt | {i_illegal_op, i_wosc_fail, i_posc_fail,
            i_wdt_pulse};
    end

    // Registers written by software and hardware
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            gie_r <= 1'b0; // [RULE16]
            req_r <= `VIP_RST_REQ;
            trap_r <= 4'h0;
            lvlh_r <= `VIP_RST_LVL;
            lvll_r <= `VIP_RST_LVL;
            edge_r <= `VIP_RST_EDGE;
            stat_r <= {`VIP_NSTAT{1'b0}};
            irq_en_r <= {`VIP_NSTAT{1'b0}};
        end else begin
            req_r <= req_nxt;
            trap_r <= trap_nxt;
            // Master enable: clears win over sets
            if (i_di || ack_go || i_trap_op || i_illegal_op ||
                    i_posc_fail || i_wosc_fail) begin
                gie_r <= 1'b0; // [RULE16]
            end else if (wr && i_paddr == `VIP_OFS_CTRL) begin
                gie_r <= i_pwdata[`VIP_CTRL_GIE_BIT]; // [RULE16]
            end else if (i_ei || i_iret) begin
                gie_r <= 1'b1; // [RULE16]
            end
            if (wr && i_paddr == `VIP_OFS_LVLH) begin
                lvlh_r <= i_pwdata[NS-1:0]; // [RULE7]
            end
            if (wr && i_paddr == `VIP_OFS_LVLL) begin
                lvll_r <= i_pwdata[NS-1:0]; // [RULE7]
            end
            if (wr && i_paddr == `VIP_OFS_EDGE) begin
                edge_r <= i_pwdata[7:0]; // [RULE4]
            end
            if (wr && i_paddr == `VIP_OFS_EN) begin
                irq_en_r <= i_pwdata[`VIP_NSTAT-1:0];
            end
            // Sticky status, set wins over clear
            stat_r <= (stat_r & ~((wr && i_paddr == `VIP_OFS_CLR) ?
                i_pwdata[`VIP_NSTAT-1:0] : {`VIP_NSTAT{1'b0}})) |
                {ack_go, trap_nxt[3:0] & ~trap_r};
        end
    end

    // ---------------------------------------------------------------
    // Priority resolution
    // ---------------------------------------------------------------
    // Traps first in fixed order, then level 3, 2, 1 by slot order
    always @* begin
        win_slot = {NS{1'b0}};
        win_trap = 4'h0;
        win_vec = `VIP_VEC_RESET;
        found = 1'b0;
        // Watchdog at level 3 ahead of the traps, needs master enable
        if (trap_r[0] && gie_r) begin
            win_trap = 4'h1; // [RULE8] [RULE17]
            win_vec = `VIP_VEC_WDT;
            found = 1'b1;
        end else if (trap_r[1]) begin
            win_trap = 4'h2; // [RULE11]
            win_vec = `VIP_VEC_POSC;
            found = 1'b1;
        end else if (trap_r[2]) begin
            win_trap = 4'h4; // [RULE11]
            win_vec = `VIP_VEC_WOSC;
            found = 1'b1;
        end else if (trap_r[3]) begin
            win_trap = 4'h8; // [RULE12]
            win_vec = `VIP_VEC_ILL;
            found = 1'b1;
        end
        // Maskable slots only while the master enable is set
        for (j = 3; j >= 1; j = j - 1) begin
            for (k = 0; k < NS; k = k + 1) begin
                lv = {lvlh_r[k], lvll_r[k]};
                if (!found && gie_r && req_r[k] && lv == j[1:0]) begin
                    found = 1'b1; // [RULE17] [RULE15] [RULE10]
                    win_slot[k] = 1'b1;
                    if (k == `VIP_SLOT_ADC) begin
                        // Converter sits past the reserved gap
                        win_vec = `VIP_VEC_ADC; // [RULE14]
                    end else if (k < `VIP_SLOT_PA7) begin
                        win_vec = `VIP_VEC_T1 + {k[14:0], 1'b0}; // [RULE14]
                    end else if (k < `VIP_SLOT_PC3) begin
                        win_vec = `VIP_VEC_PA7 +
                            {k[14:0] - 15'd3, 1'b0}; // [RULE6]
                    end else begin
                        win_vec = `VIP_VEC_PC3 +
                            {k[14:0] - 15'd11, 1'b0}; // [RULE5]
                    end
                end
            end
        end
    end

    // Presented vector, registered; MSB at even, LSB at odd
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_vector_msb_addr <= `VIP_VEC_RESET; // [RULE11]
            o_vector_lsb_addr <= `VIP_VEC_RESET | 16'h0001;
            o_vector_valid <= 1'b0;
            win_slot_r <= {NS{1'b0}};
            win_trap_r <= 4'h0;
        end else if (ack_go) begin
            // Drop the taken vector for one cycle, then re-resolve
            o_vector_valid <= 1'b0;
            win_slot_r <= {NS{1'b0}};
            win_trap_r <= 4'h0;
        end else begin
            o_vector_msb_addr <= win_vec; // [RULE9]
            o_vector_lsb_addr <= win_vec | 16'h0001; // [RULE9]
            o_vector_valid <= found; // [RULE15]
            win_slot_r <= win_slot;
            win_trap_r <= win_trap;
        end
    end
endmodule

// file: vip_consts.vh
// Constants for the vectored interrupt prioritizer
`ifndef VIP_CONSTS_VH
`define VIP_CONSTS_VH
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define VIP_OFS_CTRL 8'h00
`define VIP_OFS_REQ 8'h04
`define VIP_OFS_LVLH 8'h08
`define VIP_OFS_LVLL 8'h0c
`define VIP_OFS_EDGE 8'h10
`define VIP_OFS_TRAP 8'h14
`define VIP_OFS_STAT 8'h18
`define VIP_OFS_CLR 8'h1c
`define VIP_OFS_EN 8'h20
`define VIP_OFS_VEC 8'h24
// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define VIP_CTRL_GIE_BIT 0
`define VIP_NSLOT 15
`define VIP_SLOT_T1 0
`define VIP_SLOT_T0 1
`define VIP_SLOT_ADC 2
`define VIP_SLOT_PA7 3
`define VIP_SLOT_PA6 4
`define VIP_SLOT_PC3 11
`define VIP_RST_REQ 15'h0000
`define VIP_RST_LVL 15'h0000
`define VIP_RST_EDGE 8'h00
// Status bit positions: the four trap-class events, then vector take
`define VIP_ST_WDT 0
`define VIP_ST_POSC 1
`define VIP_ST_WOSC 2
`define VIP_ST_ILL 3
`define VIP_ST_TAKEN 4
`define VIP_NSTAT 5
// ---------------------------------------------------------------
// Vector addresses
// ---------------------------------------------------------------
`define VIP_VEC_RESET 16'h0002
`define VIP_VEC_WDT 16'h0004
`define VIP_VEC_ILL 16'h0006
`define VIP_VEC_T1 16'h000a
`define VIP_VEC_T0 16'h000c
`define VIP_VEC_ADC 16'h0016
`define VIP_VEC_PA7 16'h0018
`define VIP_VEC_PC3 16'h0030
`define VIP_VEC_POSC 16'h003a
`define VIP_VEC_WOSC 16'h003c
`endif

// file: vip_props.sv
// Port assertions for the vectored interrupt prioritizer
`timescale 1ns/1ps
module vip_props (
    input wire i_clk_sys, // System clock
    input wire i_arst_n, // Reset, active low
    input wire i_psel, // APB select
    input wire i_penable, // APB enable
    input wire i_pwrite, // APB write
    input wire i_ei, // Enable instruction
    input wire i_di, // Disable instruction
    input wire i_trap_op, // Trap instruction
    input wire i_posc_fail, // Primary oscillator fail
    input wire i_wosc_fail, // Watchdog oscillator fail
    input wire i_illegal_op, // Illegal instruction
    input wire i_ack, // Core takes the vector
    input wire [15:0] o_vector_msb_addr, // Even vector address
    input wire [15:0] o_vector_lsb_addr, // Odd vector address
    input wire o_vector_valid, // Vector presented
    input wire o_global_irq_enable // Master enable
);
    // ------------------------------
    // Helpers and clocking
    // ------------------------------
    wire trap_w = i_trap_op | i_posc_fail | i_wosc_fail | i_illegal_op;
    wire wr_w = i_psel & i_penable & i_pwrite;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_arst_n);
    vec_pair_a: assert property (
        o_vector_lsb_addr == {o_vector_msb_addr[15:1], 1'b1}
        && !o_vector_msb_addr[0]) else $error("vector bytes not paired");
    no_reserved_a: assert property (
        o_vector_valid |-> !(o_vector_msb_addr inside {16'h0002, 16'h0008,
        16'h000e, 16'h0010, 16'h0012, 16'h0014, 16'h0028, 16'h002a,
        16'h002c, 16'h002e, 16'h0038})) else $error("reserved vector");
    ack_drop_a: assert property (
        i_ack && o_vector_valid |=> !o_vector_valid && !o_global_irq_enable)
        else $error("ack did not withdraw vector");
    clear_en_a: assert property (
        i_di || trap_w |=> !o_global_irq_enable)
        else $error("master enable not cleared");
    set_en_a: assert property (
        i_ei && !(i_di || i_ack || trap_w || wr_w) |=> o_global_irq_enable)
        else $error("master enable not set");
    masked_a: assert property (
        $rose(o_vector_valid) && o_vector_msb_addr >= 16'h000a
        && o_vector_msb_addr <= 16'h0036 |-> $past(o_global_irq_enable))
        else $error("maskable vector while disabled");
    posc_first_a: assert property (
        i_posc_fail && !o_global_irq_enable && !o_vector_valid
        ##1 !o_global_irq_enable && !o_vector_valid
        |=> o_vector_valid && o_vector_msb_addr == 16'h003a)
        else $error("oscillator trap not presented first");
    stay_a: assert property (
        o_vector_valid && !(i_ack || i_di || trap_w || wr_w)
        |=> o_vector_valid) else $error("pending vector dropped");
endmodule

// file: core_model.sv
// Processor core model that takes vectors and returns from routines
`timescale 1ns/1ps
module core_model (
    input wire i_clk_sys, // System clock
    input wire i_arst_n, // Reset, active low
    input wire i_vector_valid, // Vector presented
    input wire [15:0] i_vector_msb_addr, // Presented vector
    input wire [3:0] i_delay, // Wait and routine length
    output reg o_ack, // Takes the vector
    output reg o_iret, // Return from the routine
    output reg [15:0] o_taken, // Last vector taken
    output reg [7:0] o_n_taken // Vectors taken so far
);
    reg [3:0] cnt_r;
    reg busy_r;
    // Wait, take one vector, run the routine, then return
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_ack <= 1'b0;
            o_iret <= 1'b0;
            o_taken <= 16'h0000;
            o_n_taken <= 8'h00;
            cnt_r <= 4'h0;
            busy_r <= 1'b0;
        end else begin
            o_iret <= 1'b0;
            cnt_r <= cnt_r + 4'h1;
            if (o_ack) begin
                o_ack <= 1'b0; // One take per presentation
                o_taken <= i_vector_msb_addr;
                o_n_taken <= o_n_taken + 8'h01;
                busy_r <= 1'b1;
                cnt_r <= 4'h0;
            end else if (busy_r && cnt_r == i_delay) begin
                busy_r <= 1'b0;
                o_iret <= 1'b1; // Return re-enables
            end else if (!busy_r && !i_vector_valid) begin
                cnt_r <= 4'h0;
            end else if (!busy_r && cnt_r == i_delay) begin
                o_ack <= 1'b1;
            end
        end
    end
endmodule

// file: tb_vectored_interrupt_prioritizer.sv
// Self-checking bench for the vectored interrupt prioritizer
`timescale 1ns/1ps
`include "vip_consts.vh"
module tb_vectored_interrupt_prioritizer;
    logic i_clk_sys = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic [7:0] i_port_a = 8'h00;
    logic [3:0] i_port_c = 4'h0;
    logic [7:0] src = 8'h00;
    logic [2:0] ins = 3'h0;
    logic [3:0] dly = 4'h1;
    logic [7:0] seen_n = 8'h00;
    logic [31:0] rdq;
    logic err;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    wire [31:0] o_prdata;
    wire o_pready, o_pslverr, o_vector_valid, o_global_irq_enable, o_irq;
    wire [15:0] o_vector_msb_addr, o_vector_lsb_addr, taken;
    wire i_t1_pulse, i_t0_pulse, i_adc_pulse, i_cmp_pulse, i_wdt_pulse;
    wire i_posc_fail, i_wosc_fail, i_illegal_op, i_ei, i_di, i_trap_op;
    wire i_ack, i_iret;
    wire [7:0] n_taken;
    assign {i_illegal_op, i_wosc_fail, i_posc_fail, i_wdt_pulse} = src[7:4];
    assign {i_cmp_pulse, i_adc_pulse, i_t0_pulse, i_t1_pulse} = src[3:0];
    assign {i_trap_op, i_di, i_ei} = ins;
    vectored_interrupt_prioritizer DUT (
        .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_t1_pulse(i_t1_pulse),
        .i_t0_pulse(i_t0_pulse), .i_adc_pulse(i_adc_pulse),
        .i_cmp_pulse(i_cmp_pulse), .i_wdt_pulse(i_wdt_pulse),
        .i_posc_fail(i_posc_fail), .i_wosc_fail(i_wosc_fail),
        .i_illegal_op(i_illegal_op), .i_port_a(i_port_a),
        .i_port_c(i_port_c), .i_ei(i_ei), .i_di(i_di), .i_iret(i_iret),
        .i_trap_op(i_trap_op), .i_ack(i_ack),
        .o_vector_msb_addr(o_vector_msb_addr),
        .o_vector_lsb_addr(o_vector_lsb_addr),
        .o_vector_valid(o_vector_valid),
        .o_global_irq_enable(o_global_irq_enable), .o_irq(o_irq));
    core_model core (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
        .i_vector_valid(o_vector_valid), .i_vector_msb_addr(o_vector_msb_addr),
        .i_delay(dly), .o_ack(i_ack), .o_iret(i_iret), .o_taken(taken),
        .o_n_taken(n_taken));
    // ------------------------------
    // Clock, timeout and tasks
    // ------------------------------
    initial forever #5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Setup, access until ready, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input [31:0] d);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        do @(posedge i_clk_sys); while (o_pready !== 1'b1);
        rdq = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), rdq, e);
    endtask
    // One-cycle source and instruction pulses
    task automatic kick(input logic [7:0] s, input logic [2:0] c);
        src <= s;
        ins <= c;
        @(posedge i_clk_sys);
        src <= 8'h00;
        ins <= 3'h0;
        @(posedge i_clk_sys);
    endtask
    task automatic take(input logic [15:0] e);
        int t;
        t = 0;
        while (n_taken == seen_n && t < 200) begin
            @(posedge i_clk_sys);
            t++;
        end
        seen_n = n_taken;
        check("vector", t < 200 ? taken : 16'hffff, e);
    endtask
    task automatic quiet;
        repeat (25) @(posedge i_clk_sys);
        check("no vector", n_taken, seen_n);
    endtask
    function automatic logic [15:0] vec_of(input int s);
        if (s < 3)
            return s == 2 ? 16'h0016 : 16'h000a + 16'(2 * s);
        if (s < 11)
            return 16'h0018 + 16'(2 * (s - 3));
        return 16'h0030 + 16'(2 * (s - 11));
    endfunction
    // ------------------------------
    // Test sequence
    // ------------------------------
    initial begin
        repeat (10) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        @(posedge i_clk_sys);
        for (int i = 0; i < 10; i++) begin
            rd(8'(4 * i), i == 9 ? 32'h2 : 32'h0);
        end
        rd(8'h40, 32'h0);
        check("slverr", err, 1'b1);
        wr(`VIP_OFS_LVLL, 32'h7fff);
        kick(8'h01, 3'h0);
        rd(`VIP_OFS_REQ, 32'h1);
        check("valid", o_vector_valid, 1'b0);
        wr(`VIP_OFS_REQ, 32'h0);
        rd(`VIP_OFS_REQ, 32'h0);
        wr(`VIP_OFS_REQ, 32'h7fff);
        wr(`VIP_OFS_CTRL, 32'h1);
        for (int s = 0; s < 15; s++) begin
            take(vec_of(s));
        end
        rd(`VIP_OFS_REQ, 32'h0);
        repeat (25) @(posedge i_clk_sys);
        kick(8'h00, 3'h2);
        dly <= 4'h9;
        wr(`VIP_OFS_LVLH, 32'h4008);
        wr(`VIP_OFS_LVLL, 32'h4003);
        wr(`VIP_OFS_REQ, 32'h400f);
        kick(8'h00, 3'h1);
        take(16'h0036);
        take(16'h0018);
        take(16'h000a);
        take(16'h000c);
        rd(`VIP_OFS_REQ, 32'h4);
        wr(`VIP_OFS_REQ, 32'h0);
        rd(`VIP_OFS_REQ, 32'h0);
        wr(`VIP_OFS_LVLH, 32'h0);
        wr(`VIP_OFS_LVLL, 32'h7fff);
        dly <= 4'h1;
        for (int i = 0; i < 4; i++) begin
            kick(8'(1 << i), 3'h0);
            take(i == 3 ? 16'h001a : vec_of(i));
        end
        wr(`VIP_OFS_EDGE, 32'h80);
        i_port_a <= 8'h80;
        take(16'h0018);
        i_port_a <= 8'hc0;
        quiet();
        i_port_a <= 8'h80;
        take(16'h001a);
        i_port_c <= 4'h8;
        take(16'h0030);
        i_port_c <= 4'h0;
        take(16'h0030);
        kick(8'h10, 3'h0);
        take(16'h0004);
        repeat (25) @(posedge i_clk_sys);
        kick(8'h00, 3'h2);
        kick(8'he0, 3'h0);
        take(16'h003a);
        take(16'h003c);
        take(16'h0006);
        repeat (25) @(posedge i_clk_sys);
        kick(8'h00, 3'h2);
        kick(8'h10, 3'h0);
        quiet();
        kick(8'h00, 3'h1);
        take(16'h0004);
        rd(`VIP_OFS_STAT, 32'h1f);
        wr(`VIP_OFS_EN, 32'h1);
        check("irq", o_irq, 1'b1);
        wr(`VIP_OFS_EN, 32'h0);
        check("irq", o_irq, 1'b0);
        wr(`VIP_OFS_EN, 32'h1);
        wr(`VIP_OFS_CLR, 32'h1);
        check("irq", o_irq, 1'b0);
        rd(`VIP_OFS_STAT, 32'h1e);
        kick(8'h00, 3'h4);
        rd(`VIP_OFS_CTRL, 32'h0);
        stop_test();
    end
endmodule
bind vectored_interrupt_prioritizer vip_props props (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_ei(i_ei), .i_di(i_di),
    .i_trap_op(i_trap_op), .i_posc_fail(i_posc_fail),
    .i_wosc_fail(i_wosc_fail), .i_illegal_op(i_illegal_op), .i_ack(i_ack),
    .o_vector_msb_addr(o_vector_msb_addr),
    .o_vector_lsb_addr(o_vector_lsb_addr),
    .o_vector_valid(o_vector_valid),
    .o_global_irq_enable(o_global_irq_enable));
